// file: hdl/dtst_debug_seq.sv
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module dtst_debug_seq
(
    // Clock and reset.
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    // AHB-Lite slave.
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic [31:0]               hrdata,
    output logic                      hresp,
    // Core side.
    input  wire dtst_pkg::dtst_hit_t   coreHit,
    input  wire dtst_pkg::dtst_trace_t traceIn,
    input  wire logic                 bdmActive,
    // Debug outputs.
    output logic                      bkptReq,
    output logic                      armed,
    output logic [2:0]                curStateFlags
);
    import dtst_pkg::*;

    // ========================================================
    // Bus slave
    dtst_cmd_t   cmd_q;
    dtst_state_t state_q;
    dtst_state_t state_d;
    logic        armBit_q;
    logic [1:0]  align_q;
    logic        tsrc_q;
    logic        range_q;
    logic        trigBrk_q;
    logic [11:0] sc_q [3];
    logic [3:0]  brkEn_q;
    logic [6:0]  count_q;
    logic [6:0]  postCnt_q;
    logic [5:0]  wrPtr_q;
    logic [5:0]  rdPtr_q;
    logic        halfSel_q;
    logic        endByBrk_q;
    logic        endByBrk_d;
    logic        bkptReq_q;
    logic [63:0] traceRam [64];
    logic [31:0] rdData;
    logic [2:0]  ssf;

    // The slave never waits and never errors, so reads see the latched address.
    wire logic addrTake = hsel & htrans[1] & hready;
    wire logic wrCtrl   = cmd_q.sel & cmd_q.write & (cmd_q.addr == OFS_CTRL);
    wire logic wrAlias  = cmd_q.sel & cmd_q.write & (cmd_q.addr == OFS_ALIAS);
    wire logic wrSc1    = cmd_q.sel & cmd_q.write & (cmd_q.addr == OFS_SC1);
    wire logic wrSc2    = cmd_q.sel & cmd_q.write & (cmd_q.addr == OFS_SC2);
    wire logic wrSc3    = cmd_q.sel & cmd_q.write & (cmd_q.addr == OFS_SC3);
    wire logic wrBrkEn  = cmd_q.sel & cmd_q.write & (cmd_q.addr == OFS_BRKEN);
    wire logic rdWinH   = cmd_q.sel & ~cmd_q.write & (cmd_q.addr == OFS_WINH);
    wire logic rdWinL   = cmd_q.sel & ~cmd_q.write & (cmd_q.addr == OFS_WINL);
    wire logic armSet   = wrCtrl & hwdata[CTRL_ARM_BIT];
    wire logic armClr   = wrCtrl & ~hwdata[CTRL_ARM_BIT];
    wire logic swTrig   = (wrCtrl | wrAlias) & hwdata[CTRL_SOFTWARE_IMMEDIATE_TRIGGER_BIT];

    // Latch the address phase; only the low byte of the address is decoded.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            cmd_q <= '0;
        else if (hready)
            cmd_q <= '{sel: addrTake, write: hwrite, addr: haddr[7:0]};
    end

    // Control registers written in the data phase.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            align_q   <= ALIGN_RST;
            tsrc_q    <= 1'b0;
            range_q   <= 1'b0;
            trigBrk_q <= 1'b0;
            brkEn_q   <= BRKEN_RST;
            sc_q      <= '{SC_RST, SC_RST, SC_RST};
        end
        else
        begin
            if (wrCtrl)
            begin
                align_q   <= hwdata[CTRL_ALIGN_LSB +: 2];
                tsrc_q    <= hwdata[CTRL_TSRC_BIT];
                range_q   <= hwdata[CTRL_RANGE_BIT];
                trigBrk_q <= hwdata[CTRL_TRGBRK_BIT];
            end
            if (wrBrkEn)
                brkEn_q <= hwdata[3:0];
            if (wrSc1)
                sc_q[0] <= hwdata[11:0];
            if (wrSc2)
                sc_q[1] <= hwdata[11:0];
            if (wrSc3)
                sc_q[2] <= hwdata[11:0];
        end
    end

    // ========================================================
    // Trigger resolution
    wire logic [3:0] chHit = coreHit.forceHit | coreHit.tagHit;
    // Range mode drops comparator C's hit while channel 0 also hits; a hit of C alone still counts.
    wire logic [3:0] chEff = chHit & ~{1'b0, range_q & chHit[0], 2'b00};
    wire logic stepState   = (state_q == SQ_ONE) | (state_q == SQ_TWO) | (state_q == SQ_THREE);
    wire logic [11:0] scCur = (state_q == SQ_ONE) ? sc_q[0] :
                              (state_q == SQ_TWO) ? sc_q[1] :
                              (state_q == SQ_THREE) ? sc_q[2] : 12'h000;
    logic [3:0] chValid;
    logic [3:0] chToFinal;
    logic [2:0] chCode [4];

    // Each channel looks up its next state in the current state's control.
    for (genvar i = 0; i < 4; i++)
    begin : g_chan
        assign chCode[i]    = scCur[3*i +: 3];
        assign chValid[i]   = stepState & chEff[i] & (chCode[i] != NXT_STAY);
        assign chToFinal[i] = chValid[i] & (chCode[i] == NXT_FINAL);
    end

    wire logic anyFinal = |chToFinal;
    wire logic winValid = |chValid;
    wire logic [3:0] candidates = anyFinal ? chToFinal : chValid;
    // A lower channel number wins among equal candidates.
    wire logic [1:0] winIdx = candidates[0] ? 2'd0 :
                              candidates[1] ? 2'd1 :
                              candidates[2] ? 2'd2 : 2'd3;
    wire logic [2:0] winCode = chCode[winIdx];
    wire logic traceOn       = tsrc_q;
    wire logic [6:0] target  = (align_q == ALIGN_MID) ? MID_LINES : BEGIN_LINES;
    // Final ends at once unless a mid or begin trace still needs lines and no breakpoint-enabled channel ended the session.
    wire logic sessionDone   = endByBrk_q | ~traceOn | (align_q == ALIGN_END) | (postCnt_q >= target);
    wire logic swToFinal     = traceOn & (align_q != ALIGN_END);

    // ========================================================
    // State sequencer
    always_comb
    begin
        state_d    = state_q;
        endByBrk_d = endByBrk_q;
        case (state_q)
            SQ_IDLE:
            begin
                endByBrk_d = 1'b0;
                if (armSet)
                    state_d = SQ_ONE;
            end
            SQ_ONE, SQ_TWO, SQ_THREE:
            begin
                if (swTrig)
                    state_d = swToFinal ? SQ_FINAL : SQ_IDLE;
                else if (armClr)
                    state_d = SQ_IDLE;
                else if (winValid)
                begin
                    case (winCode)
                        NXT_ONE:   state_d = SQ_ONE;
                        NXT_TWO:   state_d = SQ_TWO;
                        NXT_THREE: state_d = SQ_THREE;
                        default:   state_d = SQ_FINAL;
                    endcase
                    if (anyFinal & brkEn_q[winIdx])
                        endByBrk_d = 1'b1;
                end
            end
            SQ_FINAL:
            begin
                // Final leaves only to state 0; arm writes here are overridden.
                if (sessionDone)
                    state_d = SQ_IDLE;
            end
            default:
                state_d = SQ_IDLE;
        endcase
    end

    // The arm bit simply mirrors the sequencer, so a hardware disarm always wins over an arm write.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q    <= SQ_IDLE;
            endByBrk_q <= 1'b0;
            armBit_q   <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            endByBrk_q <= endByBrk_d;
            armBit_q   <= (state_d != SQ_IDLE);
        end
    end

    // Current state flags follow the state at every transition.
    always_comb
    begin
        case (state_q)
            SQ_ONE:   ssf = SSF_ONE;
            SQ_TWO:   ssf = SSF_TWO;
            SQ_THREE: ssf = SSF_THREE;
            SQ_FINAL: ssf = SSF_FINAL;
            default:  ssf = SSF_IDLE;
        endcase
    end

    // ========================================================
    // Breakpoint requests
    wire logic brkChan  = armBit_q & |(chEff & brkEn_q);
    wire logic brkSw    = stepState & swTrig & ~swToFinal & trigBrk_q;
    // Tracing sessions hold the breakpoint back until the last line.
    wire logic brkFinal = (state_q == SQ_FINAL) & sessionDone & trigBrk_q & ~endByBrk_q;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            bkptReq_q <= 1'b0;
        else
            bkptReq_q <= brkChan | brkSw | brkFinal;
    end

    // ========================================================
    // Trace store
    wire logic enterFinal = (state_d == SQ_FINAL) & (state_q != SQ_FINAL);
    wire logic preWindow  = stepState & (align_q != ALIGN_BEGIN);
    wire logic postWindow = (state_q == SQ_FINAL) & (align_q != ALIGN_END) & ~endByBrk_q & (postCnt_q < target);
    wire logic cofEntry   = enterFinal & (align_q == ALIGN_BEGIN) & traceIn.isCof;
    // Begin alignment stores nothing before Final except a COF entry in the cycle that enters Final.
    wire logic store      = traceIn.valid & ~bdmActive & traceOn & (preWindow | postWindow | cofEntry);

    // Pointers and counters; the count saturates so it never wraps to zero.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count_q   <= 7'h00;
            postCnt_q <= 7'h00;
            wrPtr_q   <= 6'h00;
        end
        else if (state_q == SQ_IDLE && armSet)
        begin
            count_q   <= 7'h00;
            postCnt_q <= 7'h00;
            wrPtr_q   <= 6'h00;
        end
        else if (store)
        begin
            wrPtr_q <= wrPtr_q + 6'h01;
            if (count_q != COUNT_MAX)
                count_q <= count_q + 7'h01;
            if (postWindow | cofEntry)
                postCnt_q <= postCnt_q + 7'h01;
        end
    end

    // The RAM has no reset; its content is only meaningful up to the count.
    always_ff @(posedge sys_clk)
    begin
        if (store)
            traceRam[wrPtr_q] <= traceIn.data;
    end

    // ========================================================
    // Trace read window
    wire logic [63:0] curLine = traceRam[rdPtr_q];
    wire logic [31:0] curHalf = halfSel_q ? curLine[31:0] : curLine[63:32];
    wire logic [5:0]  oldest  = (count_q >= BEGIN_LINES) ? wrPtr_q : (wrPtr_q - count_q[5:0]);
    wire logic        sessEnd = (state_q != SQ_IDLE) & (state_d == SQ_IDLE);

    // Four 16-bit reads make a line; the low word of the second half advances it.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdPtr_q   <= 6'h00;
            halfSel_q <= 1'b0;
        end
        else if (sessEnd)
        begin
            rdPtr_q   <= oldest;
            halfSel_q <= 1'b0;
        end
        else if (rdWinL & ~armBit_q)
        begin
            halfSel_q <= ~halfSel_q;
            if (halfSel_q)
                rdPtr_q <= rdPtr_q + 6'h01;
        end
    end

    // Read mux; unmapped and write-only offsets read as zero.
    always_comb
    begin
        rdData = 32'h0000_0000;
        case (cmd_q.addr)
            OFS_CTRL:   rdData = {25'h0, trigBrk_q, range_q, tsrc_q, align_q, 1'b0, armBit_q};
            OFS_STATUS: rdData = {29'h0, ssf};
            OFS_SC1:    rdData = {20'h0, sc_q[0]};
            OFS_SC2:    rdData = {20'h0, sc_q[1]};
            OFS_SC3:    rdData = {20'h0, sc_q[2]};
            OFS_BRKEN:  rdData = {28'h0, brkEn_q};
            OFS_COUNT:  rdData = {25'h0, count_q};
            OFS_WINH:   rdData = armBit_q ? 32'h0000_0000 : {16'h0, curHalf[31:16]};
            OFS_WINL:   rdData = armBit_q ? 32'h0000_0000 : {16'h0, curHalf[15:0]};
            default:    rdData = 32'h0000_0000;
        endcase
    end

    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign hrdata        = (cmd_q.sel & ~cmd_q.write) ? rdData : 32'h0000_0000;
    assign bkptReq       = bkptReq_q;
    assign armed         = armBit_q;
    assign curStateFlags = ssf;

    // ========================================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_low_chan_wins: assert property (winValid && chValid[0] && !anyFinal |-> winIdx == 2'd0)
        else $error("lower channel did not win");
    a_final_match_first: assert property (anyFinal |-> chToFinal[winIdx])
        else $error("final-bound match lost priority");
    a_range_fold: assert property (range_q && chHit[0] && chHit[2] |-> chEff[0] && !chEff[2])
        else $error("range match2 not suppressed");
    a_disarm_wins_arm: assert property (((stepState && swTrig && !swToFinal) || (state_q == SQ_FINAL && sessionDone)) && armSet |=> !armBit_q && state_q == SQ_IDLE)
        else $error("arm write beat hardware disarm");
    a_swtrig_target: assert property (stepState && swTrig |=> state_q == ($past(swToFinal) ? SQ_FINAL : SQ_IDLE))
        else $error("software trigger went to wrong state");
    a_arm_to_one: assert property (state_q == SQ_IDLE && armSet |=> state_q == SQ_ONE && ssf == SSF_ONE)
        else $error("arm did not enter state one");
    a_final_exit_only: assert property (state_q == SQ_FINAL |=> state_q inside {SQ_FINAL, SQ_IDLE})
        else $error("illegal exit from final");
    a_brk_end_pass: assert property (state_q != SQ_FINAL ##1 state_q == SQ_FINAL && endByBrk_q |=> state_q == SQ_IDLE)
        else $error("breakpoint end did not leave final");
    a_chan_brk: assert property (brkChan |=> bkptReq)
        else $error("channel breakpoint missed");
    a_no_store_bdm: assert property (bdmActive |-> !store)
        else $error("stored during background debug");
    a_count_step: assert property (store && count_q != COUNT_MAX |=> count_q == $past(count_q) + 7'h01)
        else $error("trace count not incremented");
    a_armed_read_hold: assert property (rdWinL && armBit_q && !sessEnd |=> $stable(rdPtr_q) && $stable(halfSel_q))
        else $error("armed read moved pointer");
    a_end_align_stop: assert property (state_q == SQ_FINAL && traceOn && align_q == ALIGN_END |=> state_q == SQ_IDLE)
        else $error("end alignment did not stop");
    a_begin_no_pre: assert property (stepState && align_q == ALIGN_BEGIN && !enterFinal |-> !store)
        else $error("begin alignment stored early");

    c_mid_session: cover property (state_q == SQ_FINAL && align_q == ALIGN_MID ##1 state_q == SQ_IDLE);
    c_line_read: cover property (rdWinL && !armBit_q && halfSel_q);
    c_chan_final: cover property (anyFinal && state_q == SQ_TWO);
    c_sw_trigger: cover property (stepState && swTrig);

endmodule

`default_nettype wire

// file: hdl/dtst_pkg.sv
package dtst_pkg;

    // ========================================================
    // Register byte offsets on the bus.
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SC1    = 8'h08;
    localparam logic [7:0] OFS_SC2    = 8'h0c;
    localparam logic [7:0] OFS_SC3    = 8'h10;
    localparam logic [7:0] OFS_BRKEN  = 8'h14;
    localparam logic [7:0] OFS_COUNT  = 8'h18;
    localparam logic [7:0] OFS_WINH   = 8'h1c;
    localparam logic [7:0] OFS_WINL   = 8'h20;
    localparam logic [7:0] OFS_ALIAS  = 8'h24;

    // ========================================================
    // Field positions of debug_control_one and its alias.
    localparam int CTRL_ARM_BIT    = 0;
    localparam int CTRL_SOFTWARE_IMMEDIATE_TRIGGER_BIT   = 1;
    localparam int CTRL_ALIGN_LSB  = 2;
    localparam int CTRL_TSRC_BIT   = 4;
    localparam int CTRL_RANGE_BIT  = 5;
    localparam int CTRL_TRGBRK_BIT = 6;

    // ========================================================
    // Alignment codes, next-state codes and state flag values.
    localparam logic [1:0] ALIGN_END   = 2'h0;
    localparam logic [1:0] ALIGN_MID   = 2'h1;
    localparam logic [1:0] ALIGN_BEGIN = 2'h2;
    localparam logic [2:0] NXT_STAY    = 3'h0;
    localparam logic [2:0] NXT_ONE     = 3'h1;
    localparam logic [2:0] NXT_TWO     = 3'h2;
    localparam logic [2:0] NXT_THREE   = 3'h3;
    localparam logic [2:0] NXT_FINAL   = 3'h4;
    localparam logic [2:0] SSF_IDLE    = 3'h0;
    localparam logic [2:0] SSF_ONE     = 3'h1;
    localparam logic [2:0] SSF_TWO     = 3'h2;
    localparam logic [2:0] SSF_THREE   = 3'h3;
    localparam logic [2:0] SSF_FINAL   = 3'h4;

    // ========================================================
    // Reset values and trace counts.
    localparam logic [11:0] SC_RST      = 12'h000;
    localparam logic [3:0]  BRKEN_RST   = 4'h0;
    localparam logic [1:0]  ALIGN_RST   = 2'h0;
    localparam logic [6:0]  MID_LINES   = 7'h20;
    localparam logic [6:0]  BEGIN_LINES = 7'h40;
    localparam logic [6:0]  COUNT_MAX   = 7'h7f;

    typedef enum logic [2:0] {SQ_IDLE, SQ_ONE, SQ_TWO, SQ_THREE, SQ_FINAL} dtst_state_t;

    // Latched AHB address phase.
    typedef struct packed {
        logic       sel;
        logic       write;
        logic [7:0] addr;
    } dtst_cmd_t;

    // Per-channel hits from the core.
    typedef struct packed {
        logic [3:0] forceHit;
        logic [3:0] tagHit;
    } dtst_hit_t;

    // One trace entry offered by the core.
    typedef struct packed {
        logic        valid;
        logic        isCof;
        logic [63:0] data;
    } dtst_trace_t;

endpackage

// file: verif/dtst_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// ====
// Core model: hit pulses, trace stream, debug mode.
module dtst_core_model
import dtst_pkg::*;
(
    // Clock and reset.
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    // Bench commands.
    input  wire logic [7:0]            hitCmd,
    input  wire logic                  streamOn,
    input  wire logic                  bdmOn,
    // Core outputs.
    output var dtst_pkg::dtst_hit_t    coreHit,
    output var dtst_pkg::dtst_trace_t  traceIn,
    output var logic                   bdmActive
);
    logic [31:0] seqNo;

    // Each offered entry carries a fresh number; idle data is inverted so stale data never looks valid.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            coreHit   <= '0;
            traceIn   <= '0;
            bdmActive <= 1'b0;
            seqNo     <= '0;
        end
        else
        begin
            coreHit   <= dtst_hit_t'(hitCmd);
            traceIn   <= {streamOn, 1'b0, streamOn ? {seqNo, ~seqNo} : {~seqNo, seqNo}};
            bdmActive <= bdmOn;
            seqNo     <= seqNo + {31'h0, streamOn};
        end
    end
endmodule

`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ====
// Bench: bus tasks and register-level scenarios.
module tb_top;
    import dtst_pkg::*;
    logic sys_clk, rstn, hsel, hwrite, hreadyout, hresp, bdmActive, bkptReq, armed, streamOn, bdmOn;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0] htrans;
    logic [2:0] curStateFlags;
    logic [7:0] hitCmd;
    dtst_hit_t coreHit;
    dtst_trace_t traceIn;
    int bad_count, num_checks, bkptSeen;

    // Stimulus sources start defined; reset is held for two cycles.
    initial
    begin
        {sys_clk, rstn, hsel, hwrite, streamOn, bdmOn, haddr, hwdata, htrans, hitCmd} = '0;
        bad_count = 0;
        num_checks = 0;
        bkptSeen = 0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
    end

    // Clock of 40 ns period.
    always #20 sys_clk = ~sys_clk;

    // Breakpoint pulses are single cycles, so count them as they pass.
    always @(posedge sys_clk) if (bkptReq === 1'b1) bkptSeen++;

    dtst_debug_seq u_dtst_debug_seq (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .coreHit(coreHit),
        .traceIn(traceIn), .bdmActive(bdmActive), .bkptReq(bkptReq), .armed(armed),
        .curStateFlags(curStateFlags));
    dtst_core_model u_dtst_core_model (.sys_clk(sys_clk), .rstn(rstn), .hitCmd(hitCmd),
        .streamOn(streamOn), .bdmOn(bdmOn), .coreHit(coreHit), .traceIn(traceIn), .bdmActive(bdmActive));

    // One single transfer; the address phase is held until hready is seen high.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        v = hrdata;
    endtask

    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic st(input logic [2:0] e);
        bus(1'b0, OFS_STATUS, '0);
        chk("state", v, {29'h0, e});
    endtask

    // Hit pulse of one cycle, then time for Final to fall back to state 0.
    task automatic hit(input logic [7:0] m);
        hitCmd <= m;
        @(posedge sys_clk);
        hitCmd <= '0;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic stream(input int n);
        streamOn <= 1'b1;
        repeat (n) @(posedge sys_clk);
        streamOn <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    // Flag arguments are plain integers so that calls can pass 0 and 1; only bit 0 is used.
    function automatic logic [31:0] ctl(input logic [1:0] al, input int ts, rg, bk);
        return {25'h0, bk[0], rg[0], ts[0], al, 2'h1};
    endfunction

    task automatic final_report();
        if (bad_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles the tests need.
    initial
    begin
        #400000;
        bad_count++;
        final_report();
    end

    // ====
    // Scenarios.
    initial
    begin
        @(posedge rstn);
        @(posedge sys_clk);
        st(SSF_IDLE);
        bus(1'b0, 8'h3c, '0);
        chk("unmapped", v, '0);
        bus(1'b1, OFS_SC1, 32'h610);
        bus(1'b1, OFS_SC2, 32'h801);
        bus(1'b1, OFS_CTRL, ctl(ALIGN_END, 0, 0, 0));
        st(SSF_ONE);
        hit(8'ha0);
        st(SSF_TWO);
        hit(8'h09);
        st(SSF_IDLE);
        chk("armed", {31'h0, armed}, '0);
        bus(1'b1, OFS_SC1, 32'h102);
        bus(1'b1, OFS_CTRL, ctl(ALIGN_END, 0, 1, 0));
        hit(8'h50);
        st(SSF_TWO);
        bus(1'b1, OFS_CTRL, '0);
        bus(1'b1, OFS_BRKEN, 32'h3);
        bus(1'b1, OFS_SC1, 32'h4);
        bus(1'b1, OFS_CTRL, ctl(ALIGN_END, 0, 0, 0));
        hit(8'h20);
        st(SSF_ONE);
        hit(8'h01);
        st(SSF_IDLE);
        chk("bkpt", bkptSeen, 2);
        bus(1'b1, OFS_BRKEN, '0);
        bus(1'b1, OFS_CTRL, ctl(ALIGN_END, 0, 0, 0));
        bus(1'b1, OFS_CTRL, ctl(ALIGN_END, 0, 0, 0) | 32'h2);
        st(SSF_IDLE);
        chk("armed", {31'h0, armed}, '0);
        bus(1'b1, OFS_CTRL, ctl(ALIGN_END, 1, 0, 1));
        bus(1'b1, OFS_ALIAS, 32'h2);
        st(SSF_IDLE);
        chk("bkpt", bkptSeen, 3);
        bus(1'b1, OFS_CTRL, ctl(ALIGN_MID, 1, 0, 1));
        stream(5);
        bdmOn <= 1'b1;
        stream(3);
        bdmOn <= 1'b0;
        bus(1'b0, OFS_COUNT, '0);
        chk("count", v, 32'h5);
        bus(1'b0, OFS_WINL, '0);
        chk("armed window", v, '0);
        bus(1'b1, OFS_ALIAS, 32'h2);
        st(SSF_FINAL);
        stream(40);
        st(SSF_IDLE);
        bus(1'b0, OFS_COUNT, '0);
        chk("count", v, 32'h25);
        chk("bkpt", bkptSeen, 4);
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b0, i[0] ? OFS_WINL : OFS_WINH, '0);
            chk("window", v, {16'h0, 16'({32'(i / 4), ~32'(i / 4)} >> (16 * (3 - i % 4)))});
        end
        bus(1'b1, OFS_CTRL, ctl(ALIGN_BEGIN, 1, 0, 0));
        stream(4);
        bus(1'b0, OFS_COUNT, '0);
        chk("count", v, '0);
        bus(1'b1, OFS_ALIAS, 32'h2);
        stream(70);
        bus(1'b0, OFS_COUNT, '0);
        chk("count", v, 32'h40);
        chk("armed", {31'h0, armed}, '0);
        final_report();
    end
endmodule

`default_nettype wire
